// ===== shared/frl_consts.vh
// Constants for the flash read limit and write control block.
// Assumes an 8-bit special function register space and a 16-bit program address.
`ifndef FRL_CONSTS_VH
`define FRL_CONSTS_VH
`define FRL_SFR_PSC_ADDR     8'h8f
`define FRL_PSC_RESET        8'h00
`define FRL_PSC_WE_BIT       0
`define FRL_PSC_EE_BIT       1
`define FRL_BLOCKED_DATA     8'h00
`define FRL_LIMIT_LOW_BYTE   8'h00
`define FRL_PAGE_MASK        16'hfe00
`define FRL_OP_TIME_NS       40
`define FRL_CLK_PERIOD_NS    4
`define FRL_OP_CYCLES        ((`FRL_OP_TIME_NS + `FRL_CLK_PERIOD_NS - 1) / `FRL_CLK_PERIOD_NS)
`endif

// ===== verilog/frl_flash_mem.v
// Program flash array model: byte program, page erase, registered read data.
// Assumes the controller issues at most one operation per cycle.
`timescale 1ns/1ps
`default_nettype none
module frl_flash_mem
(
    input  wire        i_core_clk,
    input  wire [15:0] i_rd_addr,
    output reg  [7:0]  o_rd_data,
    input  wire        i_prog,
    input  wire        i_erase,
    input  wire [15:0] i_wr_addr,
    input  wire [7:0]  i_wr_data
);
    localparam integer DEPTH = 65536;
    localparam integer PAGE  = 512;
    reg [7:0] mem [0:DEPTH-1];
    integer   k;

    // Programming can only clear bits, so an unerased location keeps old zeros.
    always @(posedge i_core_clk)
    begin
        o_rd_data <= mem[i_rd_addr];
        if (i_erase)
        begin
            for (k = 0; k < PAGE; k = k + 1)
                mem[{i_wr_addr[15:9], k[8:0]}] <= 8'hff;
        end
        else if (i_prog)
            mem[i_wr_addr] <= mem[i_wr_addr] & i_wr_data;
    end
endmodule
`default_nettype wire

// ===== verilog/frl_access_ctrl.v
// Flash read limit and write control: partitions code reads at a limit taken from a
// security byte and gates flash byte writes and page erases through a control register.
// Assumes the core presents one request at a time on i_core_clk and honours the stall.
// Notes on behaviour
// R1 - Read limit is a 16-bit address; upper partition at or above it.
// R2 - Code read from upper partition targeting lower partition returns zero.
// R3 - Fetch and execution of lower code from upper code stays allowed.
// R4 - Code reads issued from the lower partition are never restricted.
// R5 - Limit is security byte in high eight bits, zeros below.
// R6 - Unprogrammed security byte is zero, so everything is readable.
// R7 - Software should pick limits on 512-byte boundaries.
// R8 - Write enable set: external write programs one flash byte; else disabled.
// R9 - Erase and write enable set: external write erases the page, data ignored.
// R10 - Software must erase a location before programming it.
// R11 - Control bits 7..2 read zero, ignore writes; register resets to zero.
// R12 - Processor stalls and interrupts defer during a flash operation.
// R13 - Requester partition is judged by the read instruction's own address.
`timescale 1ns/1ps
`default_nettype none
`include "frl_consts.vh"
module frl_access_ctrl
(
    input  wire        i_core_clk,
    input  wire        i_rst_b,
    input  wire [7:0]  i_security_byte,
    input  wire        i_sfr_wr,
    input  wire        i_sfr_rd,
    input  wire [7:0]  i_sfr_addr,
    input  wire [7:0]  i_sfr_wdata,
    output reg  [7:0]  o_sfr_rdata,
    input  wire        i_fetch,
    input  wire [15:0] i_fetch_addr,
    input  wire        i_code_rd,
    input  wire [15:0] i_code_rd_pc,
    input  wire [15:0] i_code_rd_addr,
    output reg  [7:0]  o_code_data,
    output reg         o_code_valid,
    input  wire        i_xdata_wr,
    input  wire [15:0] i_xdata_addr,
    input  wire [7:0]  i_xdata_wdata,
    output reg         o_stall,
    output reg         o_irq_hold,
    output reg  [15:0] o_read_limit_address
);
    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;
    // The operation time comes from the header as a plain integer; only its low byte is
    // kept, which is ample for any count the header can give at this clock rate.
    localparam integer OP_CYC_INT = `FRL_OP_CYCLES;
    localparam [7:0]   OP_CYC     = OP_CYC_INT[7:0];

    reg        state_q;
    reg  [7:0] op_cnt_q;
    reg        flash_write_enable_q;
    reg        page_erase_enable_q;
    reg  [7:0] sec_byte_q;
    reg        rd_pend_q;
    reg        rd_block_q;
    wire [7:0] mem_rdata;
    wire [15:0] limit;
    wire       do_prog;
    wire       do_erase;
    wire [15:0] mem_rd_addr;
    wire       op_req;
    wire       psc_wr;
    wire       psc_rd;

    // True when an address falls in the lower partition below the limit.
    function in_lower;
        input [15:0] addr;
        input [15:0] lim;
        begin
            in_lower = (addr < lim); // R1
        end
    endfunction

    // True when a register bus address selects the program store control register.
    // Read and write share this one decode so the two can never disagree.
    function psc_hit;
        input [7:0] addr;
        begin
            psc_hit = (addr == `FRL_SFR_PSC_ADDR);
        end
    endfunction

    // Limit is built from the captured security byte on a 256-byte boundary.
    assign limit = {sec_byte_q, `FRL_LIMIT_LOW_BYTE}; // R5

    // Register strobes qualified by the address decode.
    assign psc_wr = i_sfr_wr && psc_hit(i_sfr_addr);
    assign psc_rd = i_sfr_rd && psc_hit(i_sfr_addr);

    // A flash operation starts only when writes are enabled and the core is not stalled;
    // a write that arrives while busy is dropped, since a stalled core cannot issue one.
    assign op_req   = i_xdata_wr && (state_q == ST_IDLE) && flash_write_enable_q; // R8
    assign do_erase = op_req && page_erase_enable_q; // R9
    assign do_prog  = op_req && !page_erase_enable_q; // R8
    // Fetches share the read port; the core never fetches and reads code in one cycle.
    assign mem_rd_addr = i_code_rd ? i_code_rd_addr : i_fetch_addr; // R3

    // The array is private to this block; the write address and data come straight
    // from the core's external-data bus, qualified only by the two operation strobes.
    frl_flash_mem u_mem
    (
        .i_core_clk (i_core_clk),
        .i_rd_addr  (mem_rd_addr),
        .o_rd_data  (mem_rdata),
        .i_prog     (do_prog),
        .i_erase    (do_erase),
        .i_wr_addr  (i_xdata_addr),
        .i_wr_data  (i_xdata_wdata)
    );

    // Control register; the security byte is caught on every clock out of reset, so the
    // strap is never loaded by the reset itself.
    // Bits 7..2 have no storage, so writes to them vanish and reads give zero.
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            flash_write_enable_q <= 1'b0; // R11
            page_erase_enable_q  <= 1'b0; // R11
            sec_byte_q           <= 8'h00; // R6
            o_sfr_rdata          <= 8'h00;
            o_read_limit_address <= 16'h0000;
        end
        else
        begin
            sec_byte_q           <= i_security_byte;
            o_read_limit_address <= limit;
            if (psc_wr)
            begin
                flash_write_enable_q <= i_sfr_wdata[`FRL_PSC_WE_BIT];
                page_erase_enable_q  <= i_sfr_wdata[`FRL_PSC_EE_BIT];
            end
            if (psc_rd)
                o_sfr_rdata <= {6'h00, page_erase_enable_q, flash_write_enable_q}; // R11
            else
                o_sfr_rdata <= 8'h00;
        end
    end

    // Code read path: the partition test uses the reading instruction's address,
    // and blocked data are masked after the array so timing is the same either way.
    // Fetches are never masked, so upper code may still call into lower code.
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            rd_pend_q    <= 1'b0;
            rd_block_q   <= 1'b0;
            o_code_data  <= 8'h00;
            o_code_valid <= 1'b0;
        end
        else
        begin
            rd_pend_q    <= i_code_rd | i_fetch;
            rd_block_q   <= i_code_rd && !in_lower(i_code_rd_pc, limit) && in_lower(i_code_rd_addr, limit); // R2 R4 R13
            o_code_valid <= rd_pend_q;
            o_code_data  <= rd_block_q ? `FRL_BLOCKED_DATA : mem_rdata; // R2
        end
    end

    // Operation sequencer holds the core and interrupts for the operation time.
    // The counter is loaded with one less than the cycle count and the exit is taken
    // on zero, so the stall stands for exactly OP_CYC cycles. Interrupt hold follows
    // the stall register for register, so no interrupt can slip in at either end.
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            state_q    <= ST_IDLE;
            op_cnt_q   <= 8'h00;
            o_stall    <= 1'b0;
            o_irq_hold <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (do_prog || do_erase)
                    begin
                        state_q    <= ST_BUSY;
                        op_cnt_q   <= OP_CYC - 8'h01;
                        o_stall    <= 1'b1; // R12
                        o_irq_hold <= 1'b1; // R12
                    end
                end
                ST_BUSY:
                begin
                    if (op_cnt_q == 8'h00)
                    begin
                        state_q    <= ST_IDLE;
                        o_stall    <= 1'b0;
                        o_irq_hold <= 1'b0;
                    end
                    else
                        op_cnt_q <= op_cnt_q - 8'h01;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== dv/frl_checker.sv
// Port checker for the flash read limit and write control block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "frl_consts.vh"
module frl_checker
(
    input wire logic        i_core_clk,
    input wire logic        i_rst_b,
    input wire logic [7:0]  i_security_byte,
    input wire logic        i_sfr_rd,
    input wire logic [7:0]  i_sfr_addr,
    input wire logic [7:0]  o_sfr_rdata,
    input wire logic        i_fetch,
    input wire logic        i_code_rd,
    input wire logic [15:0] i_code_rd_pc,
    input wire logic [15:0] i_code_rd_addr,
    input wire logic [7:0]  o_code_data,
    input wire logic        o_code_valid,
    input wire logic        i_xdata_wr,
    input wire logic        o_stall,
    input wire logic        o_irq_hold,
    input wire logic [15:0] o_read_limit_address
);
    // All checks share the core clock and are quiet while reset is held.
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    a_limit_form: assert property ((i_rst_b && $stable(i_security_byte))[*3] |->
        o_read_limit_address == {i_security_byte, 8'h00}) else $error("read limit wrong");
    a_block_lower: assert property (i_code_rd && i_code_rd_pc >= o_read_limit_address &&
        i_code_rd_addr < o_read_limit_address |-> ##2 o_code_valid && o_code_data == `FRL_BLOCKED_DATA) else $error("leak");
    a_fetch_ok: assert property (i_fetch && !i_code_rd |-> ##2 o_code_valid) else $error("fetch lost");
    a_valid_cause: assert property (o_code_valid |-> $past(i_code_rd || i_fetch, 2)) else $error("stray valid");
    a_stall_len: assert property ($rose(o_stall) |-> o_stall[*8] ##1 o_stall[*2] ##1 !o_stall) else $error("stall");
    a_stall_cause: assert property ($rose(o_stall) |-> $past(i_xdata_wr)) else $error("stall cause");
    a_irq_pair: assert property (o_irq_hold == o_stall) else $error("irq hold");
    a_ctl_unused: assert property (i_sfr_rd && i_sfr_addr == `FRL_SFR_PSC_ADDR |=> o_sfr_rdata[7:2] == 6'h00)
        else $error("unused bits");
    a_sfr_other: assert property (i_sfr_rd && i_sfr_addr != `FRL_SFR_PSC_ADDR |=> o_sfr_rdata == 8'h00)
        else $error("unmapped read");
endmodule
`default_nettype wire

// ===== dv/frl_core_model.sv
// Processor core model issuing register, code-space and external-data requests.
// Assumes requests change on the falling edge; released buses show inverted values.
`timescale 1ns/1ps
`default_nettype none
module frl_core_model
(
    input  wire logic        i_clk,
    input  wire logic        i_stall,
    input  wire logic        i_code_valid,
    input  wire logic [7:0]  i_code_data,
    input  wire logic [7:0]  i_sfr_rdata,
    output logic             o_sfr_wr,
    output logic             o_sfr_rd,
    output logic             o_fetch,
    output logic             o_code_rd,
    output logic             o_xdata_wr,
    output logic [7:0]       o_sfr_addr,
    output logic [7:0]       o_sfr_wdata,
    output logic [7:0]       o_xdata_wdata,
    output logic [15:0]      o_code_rd_pc,
    output logic [15:0]      o_code_addr,
    output logic [15:0]      o_xdata_addr
);
    // Idle at time zero; a stalled core never starts a new request.
    initial {o_sfr_wr, o_sfr_rd, o_fetch, o_code_rd, o_xdata_wr, o_sfr_addr, o_sfr_wdata, o_xdata_wdata,
             o_code_rd_pc, o_code_addr, o_xdata_addr} = '0;
    task automatic sfr(input logic w, input logic [7:0] a, d, output logic [7:0] r);
        @(negedge i_clk);
        while (i_stall) @(negedge i_clk);
        {o_sfr_wr, o_sfr_rd, o_sfr_addr, o_sfr_wdata} = {w, !w, a, d};
        @(negedge i_clk);
        r = i_sfr_rdata;
        {o_sfr_wr, o_sfr_rd, o_sfr_addr, o_sfr_wdata} = {2'b00, ~a, ~d};
    endtask
    task automatic rd(input logic fe, input logic [15:0] p, a, output logic [7:0] r, output logic ok);
        @(negedge i_clk);
        while (i_stall) @(negedge i_clk);
        {o_fetch, o_code_rd, o_code_rd_pc, o_code_addr} = {fe, !fe, p, a};
        @(negedge i_clk);
        {o_fetch, o_code_rd, o_code_rd_pc, o_code_addr} = {2'b00, ~p, ~a};
        repeat (3) if (!i_code_valid) @(negedge i_clk);
        {ok, r} = {i_code_valid, i_code_data};
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_clk);
        while (i_stall) @(negedge i_clk);
        {o_xdata_wr, o_xdata_addr, o_xdata_wdata} = {1'b1, a, d};
        @(negedge i_clk);
        {o_xdata_wr, o_xdata_addr, o_xdata_wdata} = {1'b0, ~a, ~d};
        repeat (2) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the flash read limit and write control block.
// Assumes the block owns its flash array and an erased byte reads all ones.
`timescale 1ns/1ps
`default_nettype none
`include "frl_consts.vh"
module tb;
    logic clk = 0, rst_b = 0, sw, sr, f, cr, xw, stall, hold, vld;
    logic [7:0] sec = 8'h00, sa, swd, xd, srd, cd, r, d0, d1;
    logic [15:0] pc, ca, xa, lim, p;
    int err_total = 0, samples_checked = 0, cyc = 0, seed = 32'h5350a6f3;
    frl_access_ctrl u_frl_access_ctrl (.i_core_clk(clk), .i_rst_b(rst_b), .i_security_byte(sec), .i_sfr_wr(sw),
        .i_sfr_rd(sr), .i_sfr_addr(sa), .i_sfr_wdata(swd), .o_sfr_rdata(srd), .i_fetch(f), .i_fetch_addr(ca),
        .i_code_rd(cr), .i_code_rd_pc(pc), .i_code_rd_addr(ca), .o_code_data(cd), .o_code_valid(vld), .i_xdata_wr(xw),
        .i_xdata_addr(xa), .i_xdata_wdata(xd), .o_stall(stall), .o_irq_hold(hold), .o_read_limit_address(lim));
    frl_core_model u_frl_core_model (.i_clk(clk), .i_stall(stall), .i_code_valid(vld), .i_code_data(cd),
        .i_sfr_rdata(srd), .o_sfr_wr(sw), .o_sfr_rd(sr), .o_fetch(f), .o_code_rd(cr), .o_xdata_wr(xw),
        .o_sfr_addr(sa), .o_sfr_wdata(swd), .o_xdata_wdata(xd), .o_code_rd_pc(pc), .o_code_addr(ca),
        .o_xdata_addr(xa));
    // Clock at 4 ns; the cycle ceiling stops a hung handshake.
    initial forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000) test_done(1);
    end
    task automatic chk(input logic [15:0] g, e);
        samples_checked++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // A read must come back valid with the expected byte.
    task automatic rdc(input logic fe, input logic [15:0] a, b, input logic [7:0] e);
        logic ok;
        u_frl_core_model.rd(fe, a, b, r, ok);
        chk({7'h00, ok, r}, {8'h01, e});
    endtask
    function automatic logic [7:0] exp_rd(input logic [15:0] a, b, input logic [7:0] d);
        return (a >= {sec, 8'h00} && b < {sec, 8'h00}) ? 8'h00 : d;
    endfunction
    task automatic test_done(input int to);
        err_total += to;
        $display("errors=%0d checks=%0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(negedge clk);
        rst_b = 1;
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        u_frl_core_model.sfr(0, `FRL_SFR_PSC_ADDR, 8'h00, r);
        chk({8'h00, r}, 16'h0000);
        chk(lim, 16'h0000);
        u_frl_core_model.sfr(1, `FRL_SFR_PSC_ADDR, 8'hff, r);
        u_frl_core_model.sfr(0, `FRL_SFR_PSC_ADDR, 8'h00, r);
        chk({8'h00, r}, 16'h0003);
        u_frl_core_model.sfr(0, 8'h8e, 8'h00, r);
        chk({8'h00, r}, 16'h0000);
        // Erase both pages first, since programming only clears bits.
        u_frl_core_model.wr(16'h0010, d1);
        u_frl_core_model.wr(16'h0210, d1);
        u_frl_core_model.sfr(1, `FRL_SFR_PSC_ADDR, 8'h01, r);
        u_frl_core_model.wr(16'h0010, d0);
        u_frl_core_model.wr(16'h0210, d1);
        u_frl_core_model.sfr(1, `FRL_SFR_PSC_ADDR, 8'h00, r);
        u_frl_core_model.wr(16'h0010, 8'h00);
        rdc(0, 16'h0400, 16'h0010, d0);
        sec = 8'h02;
        repeat (3) @(negedge clk);
        chk(lim, 16'h0200);
        rdc(0, 16'h0400, 16'h0010, 8'h00);
        rdc(0, 16'h0200, 16'h01ff, 8'h00);
        rdc(0, 16'h0400, 16'h0210, d1);
        rdc(0, 16'h01ff, 16'h0010, d0);
        rdc(1, 16'h0400, 16'h0010, d0);
        for (int i = 0; i < 8; i++)
        begin
            p = 16'($random(seed));
            rdc(0, p, 16'h0010, exp_rd(p, 16'h0010, d0));
        end
        u_frl_core_model.sfr(1, `FRL_SFR_PSC_ADDR, 8'h03, r);
        u_frl_core_model.wr(16'h0000, 8'h00);
        u_frl_core_model.sfr(1, `FRL_SFR_PSC_ADDR, 8'h00, r);
        rdc(0, 16'h0100, 16'h0010, 8'hff);
        rdc(0, 16'h0100, 16'h0210, d1);
        test_done(0);
    end
endmodule
bind frl_access_ctrl frl_checker u_frl_checker
(
    .i_core_clk           (i_core_clk),
    .i_rst_b              (i_rst_b),
    .i_security_byte      (i_security_byte),
    .i_sfr_rd             (i_sfr_rd),
    .i_sfr_addr           (i_sfr_addr),
    .o_sfr_rdata          (o_sfr_rdata),
    .i_fetch              (i_fetch),
    .i_code_rd            (i_code_rd),
    .i_code_rd_pc         (i_code_rd_pc),
    .i_code_rd_addr       (i_code_rd_addr),
    .o_code_data          (o_code_data),
    .o_code_valid         (o_code_valid),
    .i_xdata_wr           (i_xdata_wr),
    .o_stall              (o_stall),
    .o_irq_hold           (o_irq_hold),
    .o_read_limit_address (o_read_limit_address)
);
`default_nettype wire
